// ===== hw/dio_pkg.sv
`default_nettype none
package dio_pkg;
   // bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_IN = 16;
   localparam int NUM_OUT = 14;
   localparam int NUM_CNT = 2;
   localparam int CNT_W = 16;

   // input banks
   localparam logic [15:0] ADDR_IN_BANK_LOW = 16'h0180;
   localparam logic [15:0] ADDR_IN_BANK_HIGH = 16'h0181;

   // output latches: one address each, first output at the base
   localparam logic [15:0] ADDR_OUT_BASE = 16'h01C0;
   localparam int OUT_GROUP_SPLIT = 8;
   localparam logic [7:0] CODE_OFF = 8'h00;
   localparam logic [7:0] CODE_ON_LOW = 8'h20;
   localparam logic [7:0] CODE_ON_HIGH = 8'h40;

   // counter channels: four bytes per channel from the base
   localparam logic [15:0] ADDR_CNT_BASE = 16'h01D0;
   localparam logic [1:0] CNT_OFS_LOW = 2'h0;
   localparam logic [1:0] CNT_OFS_HIGH = 2'h1;
   localparam logic [1:0] CNT_OFS_STAT = 2'h2;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_ARMED_BIT = 2;

   // reset values
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;

   // counter channel states, gray along idle -> count -> done
   typedef enum logic [1:0] {
      CNT_IDLE  = 2'b00,
      CNT_COUNT = 2'b01,
      CNT_DONE  = 2'b11
   } cnt_state_t;
endpackage : dio_pkg
`default_nettype wire

// ===== hw/pulse_counter_chan.sv
`default_nettype none
module pulse_counter_chan (
   input  wire logic                       clk_i,
   input  wire logic                       nrst_i,
   input  wire logic                       pulse_i,
   input  wire logic                       load_i,
   input  wire logic [dio_pkg::CNT_W-1:0]  load_val_i,
   output logic      [dio_pkg::CNT_W-1:0]  count_o,
   output logic                            edge_o,
   output logic                            armed_o,
   output logic                            done_o
);
   logic                       prev_r;
   logic [dio_pkg::CNT_W-1:0]  count_r;
   dio_pkg::cnt_state_t        state_r;
   logic                       fall;

   // falling edge against last cycle's level
   assign fall = prev_r & ~pulse_i;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= pulse_i;
      end
   end

   // down counter; a reload always wins over a pending edge
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         count_r <= dio_pkg::CNT_RST;
         state_r <= dio_pkg::CNT_IDLE;
      end else if (load_i) begin
         count_r <= load_val_i;
         state_r <= (load_val_i == dio_pkg::CNT_RST) ?
                    dio_pkg::CNT_DONE : dio_pkg::CNT_COUNT;
      end else begin
         unique case (state_r)
            dio_pkg::CNT_IDLE: begin
               state_r <= dio_pkg::CNT_IDLE;
            end
            dio_pkg::CNT_COUNT: begin
               if (fall) begin
                  count_r <= count_r - 16'h0001;
                  // terminal count does not depend on any read
                  if (count_r == 16'h0001) begin
                     state_r <= dio_pkg::CNT_DONE;
                  end
               end
            end
            dio_pkg::CNT_DONE: begin
               state_r <= dio_pkg::CNT_DONE;
            end
            default: begin
               state_r <= dio_pkg::CNT_IDLE;
            end
         endcase
      end
   end

   assign count_o = count_r;
   assign edge_o = fall & (state_r == dio_pkg::CNT_COUNT);
   assign armed_o = (state_r == dio_pkg::CNT_COUNT);
   assign done_o = (state_r == dio_pkg::CNT_DONE);
endmodule : pulse_counter_chan
`default_nettype wire

// ===== hw/board_dio.sv
// Functional notes
// - a read at the low bank address returns inputs one to eight, one in bit 0.
// - a read at the high bank address returns inputs nine to sixteen, nine in bit 0.
// - each bank bit is one for a high input and zero for a low input.
// - only the low eight data bits carry input levels.
// - writing zero to any output address switches that output off.
// - code 0x20 written to outputs one to eight switches that output on.
// - code 0x40 written to outputs nine to fourteen switches that output on.
// - every output has its own address, so one write changes one output.
// - two counter channels, zero and one, each load an unsigned count.
// - a loaded channel counts falling edges and interrupts after that many.
// - the terminal interrupt comes whether or not the count was read.
// - the running count is readable and a too-fast sample is marked invalid.
`default_nettype none
module board_dio (
   input  wire logic                         clk_i,
   input  wire logic                         nrst_i,
   input  wire logic [dio_pkg::ADDR_W-1:0]   io_addr_i,
   input  wire logic                         io_wr_i,
   input  wire logic                         io_rd_i,
   input  wire logic [dio_pkg::DATA_W-1:0]   io_wdata_i,
   output logic      [dio_pkg::DATA_W-1:0]   io_rdata_o,
   output logic                              io_rvalid_o,
   input  wire logic [dio_pkg::NUM_IN-1:0]   field_in_i,
   output logic      [dio_pkg::NUM_OUT-1:0]  output_port_o,
   input  wire logic [dio_pkg::NUM_CNT-1:0]  cnt_pulse_i,
   output logic      [dio_pkg::NUM_CNT-1:0]  irq_o,
   output logic                              counter_zero_done_flag_o,
   output logic                              counter_one_done_flag_o
);
   // address decode helpers; is_cnt_addr serves the write and read paths, is_out_addr only the read path
   function automatic logic is_out_addr(input logic [15:0] a);
      is_out_addr = (a >= dio_pkg::ADDR_OUT_BASE) &&
                    (a < dio_pkg::ADDR_OUT_BASE + 16'(dio_pkg::NUM_OUT));
   endfunction : is_out_addr

   function automatic logic is_cnt_addr(input logic [15:0] a, input int ch,
                                        input logic [1:0] ofs);
      is_cnt_addr = (a == dio_pkg::ADDR_CNT_BASE + 16'(ch * 4) + 16'(ofs));
   endfunction : is_cnt_addr

   logic [dio_pkg::NUM_OUT-1:0]   out_r;
   logic [dio_pkg::DATA_W-1:0]    rdata_r;
   logic [dio_pkg::DATA_W-1:0]    rdata_nxt;
   logic                          rvalid_r;
   logic [dio_pkg::NUM_CNT-1:0]   irq_r;
   logic [dio_pkg::NUM_CNT-1:0]   load;
   logic [dio_pkg::NUM_CNT-1:0]   edge_seen;
   logic [dio_pkg::NUM_CNT-1:0]   armed;
   logic [dio_pkg::NUM_CNT-1:0]   done;
   logic [dio_pkg::NUM_CNT-1:0]   snap_ok_r;
   logic [dio_pkg::DATA_W-1:0]    stage_lo_r [dio_pkg::NUM_CNT];
   logic [dio_pkg::DATA_W-1:0]    snap_hi_r [dio_pkg::NUM_CNT];
   logic [dio_pkg::CNT_W-1:0]     count [dio_pkg::NUM_CNT];

   // output latches: each index answers only its own address
   generate
      for (genvar i = 0; i < dio_pkg::NUM_OUT; i++) begin : g_out
         localparam logic [7:0] ON_CODE = (i < dio_pkg::OUT_GROUP_SPLIT) ?
            dio_pkg::CODE_ON_LOW : dio_pkg::CODE_ON_HIGH;
         logic hit;
         assign hit = io_wr_i &&
            (io_addr_i == dio_pkg::ADDR_OUT_BASE + 16'(i));
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               out_r[i] <= 1'b0;
            end else if (hit && io_wdata_i == dio_pkg::CODE_OFF) begin
               out_r[i] <= 1'b0;
            end else if (hit && io_wdata_i == ON_CODE) begin
               out_r[i] <= 1'b1;
            end
            // any other code is ignored and the latch holds
         end
      end
   endgenerate

   // counter channels; the high byte write commits the staged low byte
   generate
      for (genvar c = 0; c < dio_pkg::NUM_CNT; c++) begin : g_cnt
         assign load[c] = io_wr_i &&
            is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_HIGH);

         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               stage_lo_r[c] <= dio_pkg::RDATA_RST;
            end else if (io_wr_i &&
                         is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_LOW)) begin
               stage_lo_r[c] <= io_wdata_i;
            end
         end

         // low byte read freezes the high byte so the word pairs up;
         // an edge landing in that cycle makes the pair untrustworthy
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               snap_hi_r[c] <= dio_pkg::RDATA_RST;
               snap_ok_r[c] <= 1'b0;
            end else if (io_rd_i &&
                         is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_LOW)) begin
               snap_hi_r[c] <= count[c][15:8];
               snap_ok_r[c] <= ~edge_seen[c];
            end
         end

         pulse_counter_chan u_chan (
            .clk_i      (clk_i),
            .nrst_i     (nrst_i),
            .pulse_i    (cnt_pulse_i[c]),
            .load_i     (load[c]),
            .load_val_i ({io_wdata_i, stage_lo_r[c]}),
            .count_o    (count[c]),
            .edge_o     (edge_seen[c]),
            .armed_o    (armed[c]),
            .done_o     (done[c])
         );

         // interrupt stays up until the channel is reloaded
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               irq_r[c] <= 1'b0;
            end else begin
               irq_r[c] <= done[c] & ~load[c];
            end
         end
      end
   endgenerate

   // read mux; plain decode, nothing here changes state on a bank read
   always_comb begin
      rdata_nxt = dio_pkg::RDATA_RST;
      if (io_addr_i == dio_pkg::ADDR_IN_BANK_LOW) begin
         rdata_nxt = field_in_i[7:0];
      end else if (io_addr_i == dio_pkg::ADDR_IN_BANK_HIGH) begin
         rdata_nxt = field_in_i[15:8];
      end else if (is_out_addr(io_addr_i)) begin
         rdata_nxt = dio_pkg::RDATA_RST;
      end else begin
         for (int c = 0; c < dio_pkg::NUM_CNT; c++) begin
            if (is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_LOW)) begin
               rdata_nxt = count[c][7:0];
            end else if (is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_HIGH)) begin
               rdata_nxt = snap_hi_r[c];
            end else if (is_cnt_addr(io_addr_i, c, dio_pkg::CNT_OFS_STAT)) begin
               rdata_nxt[dio_pkg::STAT_DONE_BIT] = done[c];
               rdata_nxt[dio_pkg::STAT_VALID_BIT] = snap_ok_r[c];
               rdata_nxt[dio_pkg::STAT_ARMED_BIT] = armed[c];
            end
         end
      end
   end

   // read data registered one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_r <= dio_pkg::RDATA_RST;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= io_rd_i;
         if (io_rd_i) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign io_rdata_o = rdata_r;
   assign io_rvalid_o = rvalid_r;
   assign output_port_o = out_r;
   assign irq_o = irq_r;
   assign counter_zero_done_flag_o = irq_r[0];
   assign counter_one_done_flag_o = irq_r[1];
endmodule : board_dio
`default_nettype wire

// ===== test/board_dio_properties.sv
`default_nettype none
module board_dio_checker (
   input wire logic                         clk_i,
   input wire logic                         nrst_i,
   input wire logic [dio_pkg::ADDR_W-1:0]   io_addr_i,
   input wire logic                         io_wr_i,
   input wire logic                         io_rd_i,
   input wire logic [dio_pkg::DATA_W-1:0]   io_wdata_i,
   input wire logic [dio_pkg::DATA_W-1:0]   io_rdata_o,
   input wire logic                         io_rvalid_o,
   input wire logic [dio_pkg::NUM_IN-1:0]   field_in_i,
   input wire logic [dio_pkg::NUM_OUT-1:0]  output_port_o,
   input wire logic [dio_pkg::NUM_CNT-1:0]  irq_o,
   input wire logic                         counter_zero_done_flag_o,
   input wire logic                         counter_one_done_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic       wr_out;
   logic [3:0] idx;
   // output latch writes; the low nibble picks the latch
   assign wr_out = io_wr_i && io_addr_i >= dio_pkg::ADDR_OUT_BASE
                   && io_addr_i < dio_pkg::ADDR_OUT_BASE + 16'h000E;
   assign idx = io_addr_i[3:0];
   sequence s_rd(logic [15:0] a);
      io_rd_i && io_addr_i == a;
   endsequence
   AST_RD_ANSWER: assert property (
      io_rvalid_o == $past(io_rd_i))
      else $error("read answer not one cycle after strobe");
   AST_BANK_LOW: assert property (
      s_rd(dio_pkg::ADDR_IN_BANK_LOW)
      |=> io_rdata_o == $past(field_in_i[7:0])) else $error("low bank");
   AST_BANK_HIGH: assert property (
      s_rd(dio_pkg::ADDR_IN_BANK_HIGH)
      |=> io_rdata_o == $past(field_in_i[15:8])) else $error("high bank");
   AST_OFF: assert property (
      wr_out && io_wdata_i == dio_pkg::CODE_OFF
      |=> !output_port_o[$past(idx)]) else $error("output not off");
   AST_ON_LOW: assert property (wr_out && idx < 4'h8
      && io_wdata_i == dio_pkg::CODE_ON_LOW |=> output_port_o[$past(idx)])
      else $error("low output not on");
   AST_ON_HIGH: assert property (wr_out && idx >= 4'h8
      && io_wdata_i == dio_pkg::CODE_ON_HIGH |=> output_port_o[$past(idx)])
      else $error("high output not on");
   AST_ONE_ONLY: assert property (wr_out |=> ((output_port_o
      ^ $past(output_port_o)) & ~(14'h0001 << $past(idx))) == 14'h0000)
      else $error("write changed another output");
   AST_HOLD: assert property (
      !wr_out |=> $stable(output_port_o))
      else $error("output changed without a write");
   AST_FLAGS: assert property (
      irq_o == {counter_one_done_flag_o, counter_zero_done_flag_o})
      else $error("done flags differ from irq");
endmodule : board_dio_checker
bind board_dio board_dio_checker board_dio_checker_inst (.clk_i, .nrst_i,
   .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o,
   .field_in_i, .output_port_o, .irq_o, .counter_zero_done_flag_o,
   .counter_one_done_flag_o);
`default_nettype wire

// ===== test/field_pulse_source.sv
`default_nettype none
module field_pulse_source (
   input  wire logic       clk_i,
   input  wire logic [1:0] run_i,
   output logic      [1:0] pulse_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // toggles while running: one fall per two cycles; stopping holds the
   // level so no stray fall appears at the end of a train
   initial pulse_o = 2'h0;
   always @(posedge clk_i) begin
      pulse_o <= pulse_o ^ run_i;
   end
endmodule : field_pulse_source
`default_nettype wire

// ===== test/tb_board_dio.sv
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb_board_dio;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic        io_wr_i = 1'b0;
   logic        io_rd_i = 1'b0;
   logic [7:0]  io_wdata_i = 8'h00;
   logic [15:0] field_in_i = 16'h0000;
   logic [1:0]  run = 2'h0;
   logic [7:0]  io_rdata_o;
   logic        io_rvalid_o;
   logic [13:0] output_port_o;
   logic [13:0] exp;
   logic [1:0]  cnt_pulse_i;
   logic [1:0]  irq_o;
   logic        flag0;
   logic        flag1;
   int          error_cnt = 0;
   int          n_compared = 0;
   board_dio board_dio_inst (.clk_i(clk_i), .nrst_i(nrst_i),
      .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .io_rvalid_o(io_rvalid_o), .field_in_i(field_in_i),
      .output_port_o(output_port_o), .cnt_pulse_i(cnt_pulse_i),
      .irq_o(irq_o), .counter_zero_done_flag_o(flag0),
      .counter_one_done_flag_o(flag1));
   field_pulse_source field_pulse_source_inst (.clk_i(clk_i), .run_i(run),
      .pulse_o(cnt_pulse_i));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      io_wr_i <= 1'b1;
      io_addr_i <= a;
      io_wdata_i <= d;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
      #1;
   endtask : wr
   // compares only the bits under the mask, the rest may be design choice
   task automatic rd(input logic [15:0] a, input logic [7:0] m, e);
      @(posedge clk_i);
      io_rd_i <= 1'b1;
      io_addr_i <= a;
      @(posedge clk_i);
      io_rd_i <= 1'b0;
      #1;
      `CHK(io_rvalid_o, 1'b1)
      `CHK(io_rdata_o & m, e)
   endtask : rd
   task automatic report_and_stop;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      logic [15:0] pats [2];
      logic [15:0] cb;
      pats = '{16'hA53C, 16'h5AC3};
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      #1;
      `CHK({output_port_o, irq_o}, 16'h0000)
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         field_in_i <= pats[i];
         rd(dio_pkg::ADDR_IN_BANK_LOW, 8'hFF,
            pats[i][7:0]);
         rd(dio_pkg::ADDR_IN_BANK_LOW, 8'hFF,
            pats[i][7:0]);
         rd(dio_pkg::ADDR_IN_BANK_HIGH, 8'hFF,
            pats[i][15:8]);
      end
      rd(16'h0200, 8'hFF, 8'h00);
      exp = 14'h0000;
      // the other group's code must be ignored before the right one lands
      for (int n = 0; n < 14; n++) begin
         wr(dio_pkg::ADDR_OUT_BASE + 16'(n),
            n < 8 ? dio_pkg::CODE_ON_HIGH : dio_pkg::CODE_ON_LOW);
         `CHK(output_port_o, exp)
         wr(dio_pkg::ADDR_OUT_BASE + 16'(n),
            n < 8 ? dio_pkg::CODE_ON_LOW : dio_pkg::CODE_ON_HIGH);
         exp[n] = 1'b1;
         `CHK(output_port_o, exp)
      end
      for (int n = 13; n >= 0; n -= 3) begin
         wr(dio_pkg::ADDR_OUT_BASE + 16'(n), dio_pkg::CODE_OFF);
         exp[n] = 1'b0;
         `CHK(output_port_o, exp)
      end
      for (int c = 0; c < 2; c++) begin
         cb = dio_pkg::ADDR_CNT_BASE + 16'(4 * c);
         wr(cb, 8'h03);
         wr(cb + 16'h0001, 8'h00);
         @(posedge clk_i);
         run[c] <= 1'b1;
         repeat (6) @(posedge clk_i);
         run[c] <= 1'b0;
         #1;
         `CHK(irq_o[c], 1'b0)
         repeat (4) @(posedge clk_i);
         #1;
         `CHK(irq_o, c ? 2'h3 : 2'h1)
         // counted down to zero; status: done, snapshot valid, not armed
         rd(cb, 8'hFF, 8'h00);
         rd(cb + 16'h0001, 8'hFF, 8'h00);
         rd(cb + 16'h0002, 8'h07, 8'h03);
      end
      wr(dio_pkg::ADDR_CNT_BASE, 8'h05);
      wr(dio_pkg::ADDR_CNT_BASE + 16'h0001, 8'h00);
      @(posedge clk_i);
      #1;
      `CHK(irq_o, 2'h2)
      report_and_stop();
   end
endmodule : tb_board_dio
`default_nettype wire
